// >>> rtl/espc_pkg.sv
`default_nettype none

package espc_pkg;

    // core clock rate, whole megahertz
    localparam int CLK_MHZ = 10;

    // self-timed and entry limits, microseconds
    localparam int WRITE_TIME_US = 5000;
    localparam int ARRAY_ERASE_TIME_US = 10000;
    localparam int SECTOR_ERASE_TIME_US = 10000;
    localparam int STANDBY_ENTRY_TIME_US = 100;
    localparam int POWERDOWN_ENTRY_TIME_US = 100;

    // same limits in core cycles; exact, no rounding, since CLK_MHZ is whole
    localparam int WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
    localparam int ARRAY_ERASE_CYC = ARRAY_ERASE_TIME_US * CLK_MHZ;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int STANDBY_ENTRY_CYC = STANDBY_ENTRY_TIME_US * CLK_MHZ;
    localparam int POWERDOWN_ENTRY_CYC = POWERDOWN_ENTRY_TIME_US * CLK_MHZ;

    // counter widths
    localparam int CNT_W = 17;
    localparam int BIT_CNT_W = 16;

    // opcodes, sent msb first
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] WRITE_CMD = 8'h02;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] PAGE_ERASE_CMD = 8'h42;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
    localparam logic [7:0] ARRAY_ERASE_CMD = 8'hC7;
    localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
    localparam logic [7:0] WAKE_CMD = 8'hAB;

    // frame lengths in serial clocks
    localparam logic [15:0] LEN_OPCODE = 16'h0008;
    localparam logic [15:0] LEN_STATUS = 16'h0010;
    localparam logic [15:0] LEN_ERASE = 16'h0018;
    localparam logic [15:0] LEN_WRITE_MIN = 16'h0020;

    // status byte layout
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PROT_BIT = 7;
    localparam logic [7:0] STAT_NV_MASK = 8'h8C;
    localparam logic [7:0] STAT_RESET = 8'h00;

    // synchroniser reset: {cs_n, wp_n, frame toggle}
    localparam logic [2:0] SYNC_RST = 3'h6;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_STANDBY,
        ST_BUSY,
        ST_DEEP
    } espc_state_t;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_WRITE,
        KIND_STATUS,
        KIND_PAGE_ERASE,
        KIND_SECTOR_ERASE,
        KIND_ARRAY_ERASE
    } espc_kind_t;

endpackage

`default_nettype wire

// >>> rtl/espc_sync.sv
`default_nettype none

// two-flop level synchroniser; first stage feeds only the second
module espc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // level in and synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // metastability guard
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/espc_ctrl.sv
`default_nettype none

// Contract
// [RL1] chip select low selects the device; only then is serial traffic accepted
// [RL2] chip select high deselects into standby unless a program cycle runs
// [RL3] standby is reached within 100 us of chip select rising
// [RL4] a started program cycle always runs to its end
// [RL5] select raised during a cycle means standby right after the cycle
// [RL6] serial output is high impedance whenever deselected
// [RL7] host raises select after a valid write; device starts cycle on that edge
// [RL8] byte, page write and page erase cycles finish within 5 ms
// [RL9] whole-array erase finishes within 10 ms
// [RL10] sector erase finishes within 10 ms
// [RL11] deep power-down is entered within 100 us of select rising
// [RL12] host pulls select low once after power-up; device ignores sequences before
// [RL13] read data on the output changes only after falling serial clock edges
// [RL14] protect pin low with protect enable set refuses status writes only
// [RL15] protect pin high lets every operation, status writes included, proceed
// [RL16] with enable set, pin low at any time in a status write blocks it
// [RL17] a running internal cycle ignores later protect pin activity
// [RL18] with protect enable clear the protect pin is ignored entirely
// [RL19] serial input is sampled on rising serial clock edges
// [RL20] status write opcode is 0000 0001, msb first
// [RL21] a partial or invalid sequence is dropped with no state change
module espc_ctrl
    import espc_pkg::*;
#(
    parameter int WRITE_CNT = WRITE_CYC,
    parameter int ARRAY_ERASE_CNT = ARRAY_ERASE_CYC,
    parameter int SECTOR_ERASE_CNT = SECTOR_ERASE_CYC
) (
    // core clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial link pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    // power and cycle state
    output logic busy,
    output logic standby,
    output logic deep_sleep,
    output logic cycle_start,
    output var espc_kind_t cycle_kind,
    output logic cycle_done,
    output logic [7:0] status_reg
);

    // link domain
    logic frame_rst_n;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [BIT_CNT_W-1:0] frame_bits;
    logic [7:0] opcode;
    logic [7:0] wdata;
    logic frame_tog;
    logic reading;
    logic [7:0] rd_shift;
    // core domain
    logic [7:0] stat_snap;
    logic cs_q;
    logic wp_q;
    logic tog_q;
    logic cs_d;
    logic armed;
    logic tog_seen;
    logic wp_low_seen;
    logic cs_rise;
    logic cs_fall;
    logic seq_take;
    logic prot_en;
    logic prot_block;
    logic seq_deep;
    logic seq_wake;
    logic start_go;
    espc_kind_t next_kind;
    espc_state_t state;
    logic [CNT_W-1:0] cyc_cnt;
    logic [CNT_W-1:0] cyc_load;

    // frame reset: deselect clears the bit counter and output path
    assign frame_rst_n = resetn & ~cs_n;

    // bit count restarts with every selection
    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= bit_cnt + BIT_CNT_W'(1);
        end
    end

    // shift in opcode and first data byte on rising edges [RL19]
    // these hold still once sck stops, so the core samples them after deselect
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            opcode <= 8'h00;
            wdata <= 8'h00;
            frame_bits <= '0;
            frame_tog <= 1'b0;
        end else if (!cs_n) begin // clocks meant for other devices are ignored [RL1]
            if (bit_cnt == '0) begin
                frame_tog <= ~frame_tog; // marks a frame that saw clocks
            end
            if (bit_cnt < BIT_CNT_W'(8)) begin
                opcode <= {opcode[6:0], si}; // msb first [RL20]
            end else if (bit_cnt < BIT_CNT_W'(16)) begin
                wdata <= {wdata[6:0], si};
            end
            frame_bits <= bit_cnt + BIT_CNT_W'(1);
        end
    end

    // status read: output updated only on falling edges [RL13]
    // snapshot is held still while selected, so reading it here is safe
    always_ff @(negedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            reading <= 1'b0;
            rd_shift <= 8'h00;
            so <= 1'b0;
        end else begin
            if (bit_cnt == BIT_CNT_W'(8) && opcode == STATUS_READ_CMD) begin
                reading <= 1'b1;
                rd_shift <= {stat_snap[6:0], stat_snap[7]};
                so <= stat_snap[7];
            end else if (reading) begin
                rd_shift <= {rd_shift[6:0], rd_shift[7]};
                so <= rd_shift[7]; // repeats the byte while clocked
            end
        end
    end

    // output driven only while selected [RL6]
    assign so_oe = reading & ~cs_n;

    // pins and the frame toggle enter the core domain
    espc_sync #(
        .W(3),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({cs_n, wp_n, frame_tog}),
        .q({cs_q, wp_q, tog_q})
    );

    // select edges, power-up arming and frame bookkeeping
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_d <= 1'b1;
            armed <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            cs_d <= cs_q;
            if (!cs_q) begin
                armed <= 1'b1; // first low level after reset [RL12]
            end
            if (cs_rise) begin
                tog_seen <= tog_q; // every frame consumed, taken or not
            end
        end
    end

    assign cs_rise = cs_q & ~cs_d;
    assign cs_fall = ~cs_q & cs_d;
    assign seq_take = cs_rise & armed & (tog_q != tog_seen); // [RL12]

    // protect pin low seen during the frame; set wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_low_seen <= 1'b0;
        end else if (!cs_q && !wp_q) begin
            wp_low_seen <= 1'b1; // [RL16]
        end else if (cs_fall) begin
            wp_low_seen <= 1'b0;
        end
    end

    // pin counts only while enabled [RL14] [RL15] [RL18]
    assign prot_en = status_reg[STAT_PROT_BIT];
    assign prot_block = prot_en & (wp_low_seen | ~wp_q);

    // classify the finished frame; anything else is dropped [RL21]
    always_comb begin
        next_kind = KIND_NONE;
        seq_deep = 1'b0;
        seq_wake = 1'b0;
        case (opcode)
            WRITE_CMD: begin
                if (frame_bits >= LEN_WRITE_MIN && frame_bits[2:0] == 3'h0) begin
                    next_kind = KIND_WRITE;
                end
            end
            PAGE_ERASE_CMD: begin
                if (frame_bits == LEN_ERASE) begin
                    next_kind = KIND_PAGE_ERASE;
                end
            end
            SECTOR_ERASE_CMD: begin
                if (frame_bits == LEN_ERASE) begin
                    next_kind = KIND_SECTOR_ERASE;
                end
            end
            ARRAY_ERASE_CMD: begin
                if (frame_bits == LEN_OPCODE) begin
                    next_kind = KIND_ARRAY_ERASE;
                end
            end
            STATUS_WRITE_CMD: begin
                if (frame_bits == LEN_STATUS && !prot_block) begin
                    next_kind = KIND_STATUS; // [RL14] [RL16]
                end
            end
            DEEP_SLEEP_CMD: begin
                seq_deep = (frame_bits == LEN_OPCODE);
            end
            WAKE_CMD: begin
                seq_wake = (frame_bits >= LEN_OPCODE);
            end
            default: begin
            end
        endcase
    end

    // cycle length per kind
    always_comb begin
        case (next_kind)
            KIND_SECTOR_ERASE: cyc_load = CNT_W'(SECTOR_ERASE_CNT); // [RL10]
            KIND_ARRAY_ERASE: cyc_load = CNT_W'(ARRAY_ERASE_CNT); // [RL9]
            default: cyc_load = CNT_W'(WRITE_CNT); // [RL8]
        endcase
    end

    // a valid write starts its cycle on the select rise [RL7]
    assign start_go = (state == ST_ACTIVE) & seq_take & (next_kind != KIND_NONE);

    // power state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_STANDBY;
        end else begin
            case (state)
                ST_ACTIVE: begin
                    if (start_go) begin
                        state <= ST_BUSY; // [RL7]
                    end else if (seq_take && seq_deep) begin
                        state <= ST_DEEP; // [RL11]
                    end else if (cs_q) begin
                        state <= ST_STANDBY; // [RL2] [RL3]
                    end
                end
                ST_STANDBY: begin
                    if (!cs_q) begin
                        state <= ST_ACTIVE; // [RL1]
                    end
                end
                ST_BUSY: begin
                    // select has no say until the count runs out [RL4]
                    if (cyc_cnt == CNT_W'(1)) begin
                        state <= cs_q ? ST_STANDBY : ST_ACTIVE; // [RL5]
                    end
                end
                ST_DEEP: begin
                    if (seq_take && seq_wake) begin
                        state <= ST_STANDBY;
                    end
                end
                default: begin
                    state <= ST_STANDBY;
                end
            endcase
        end
    end

    // self-timed cycle counter; pin activity cannot touch it [RL17]
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc_cnt <= '0;
        end else if (start_go) begin
            cyc_cnt <= cyc_load;
        end else if (cyc_cnt != '0) begin
            cyc_cnt <= cyc_cnt - CNT_W'(1);
        end
    end

    // cycle strobes and kind
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cycle_start <= 1'b0;
            cycle_done <= 1'b0;
            cycle_kind <= KIND_NONE;
        end else begin
            cycle_start <= start_go;
            cycle_done <= (state == ST_BUSY) && (cyc_cnt == CNT_W'(1));
            if (start_go) begin
                cycle_kind <= next_kind;
            end
        end
    end

    // nonvolatile status bits, committed when a status cycle starts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= STAT_RESET;
        end else if (start_go && next_kind == KIND_STATUS) begin
            status_reg <= (status_reg & ~STAT_NV_MASK) | (wdata & STAT_NV_MASK);
        end
    end

    // read snapshot refreshed only while deselected; busy shown may lag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat_snap <= STAT_RESET;
        end else if (cs_q) begin
            stat_snap <= status_reg;
            stat_snap[STAT_BUSY_BIT] <= (state == ST_BUSY);
        end
    end

    assign busy = (state == ST_BUSY);
    assign standby = (state == ST_STANDBY);
    assign deep_sleep = (state == ST_DEEP);

    // checking helpers
    logic [CNT_W-1:0] stby_wait;
    logic [CNT_W-1:0] busy_len;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stby_wait <= '0;
            busy_len <= '0;
        end else begin
            stby_wait <= (state == ST_ACTIVE && cs_q) ? stby_wait + CNT_W'(1) : '0;
            busy_len <= busy ? busy_len + CNT_W'(1) : '0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_frame_done;
        seq_take && state == ST_ACTIVE;
    endsequence

    sequence s_free_status;
        opcode == STATUS_WRITE_CMD && frame_bits == LEN_STATUS
            && (!prot_en || (wp_q && !wp_low_seen));
    endsequence

    a_select_wakes: assert property ( // [RL1]
        (state == ST_STANDBY && !cs_q) |=> state == ST_ACTIVE)
        else $error("select did not wake the device");

    a_deselect_standby: assert property ( // [RL2]
        (state == ST_ACTIVE && cs_q && !start_go && !(seq_take && seq_deep))
            |=> state == ST_STANDBY)
        else $error("deselect did not reach standby");

    a_standby_bound: assert property ( // [RL3]
        stby_wait <= CNT_W'(STANDBY_ENTRY_CYC))
        else $error("standby entry too slow");

    a_busy_holds: assert property ( // [RL4]
        (busy && cyc_cnt > CNT_W'(1)) |=> busy && $stable(cycle_kind))
        else $error("cycle ended early");

    a_busy_to_standby: assert property ( // [RL5]
        (busy && cyc_cnt == CNT_W'(1) && cs_q) |=> standby ##1 cycle_done == 1'b0)
        else $error("no standby after cycle");

    a_so_quiet: assert property ( // [RL6]
        cs_n |-> !so_oe)
        else $error("output driven while deselected");

    a_write_starts: assert property ( // [RL7]
        s_frame_done ##0 next_kind != KIND_NONE |=> busy && cycle_start)
        else $error("valid write did not start a cycle");

    a_write_bound: assert property ( // [RL8]
        (busy && cycle_kind inside {KIND_WRITE, KIND_STATUS, KIND_PAGE_ERASE})
            |-> busy_len < CNT_W'(WRITE_CNT))
        else $error("write cycle too long");

    a_array_bound: assert property ( // [RL9]
        (busy && cycle_kind == KIND_ARRAY_ERASE) |-> busy_len < CNT_W'(ARRAY_ERASE_CNT))
        else $error("array erase too long");

    a_sector_bound: assert property ( // [RL10]
        (busy && cycle_kind == KIND_SECTOR_ERASE) |-> busy_len < CNT_W'(SECTOR_ERASE_CNT))
        else $error("sector erase too long");

    a_deep_entry: assert property ( // [RL11]
        s_frame_done ##0 (seq_deep && next_kind == KIND_NONE) |=> deep_sleep[*2])
        else $error("deep sleep not entered");

    a_arm_first: assert property ( // [RL12]
        !armed |=> !cycle_start)
        else $error("cycle before first select");

    a_protect_block: assert property ( // [RL14]
        (seq_take && opcode == STATUS_WRITE_CMD && prot_block) |=> $stable(status_reg))
        else $error("protected status write went through");

    a_protect_free: assert property ( // [RL18]
        s_frame_done ##0 s_free_status |=> cycle_start && cycle_kind == KIND_STATUS)
        else $error("unprotected status write refused");

    a_discard: assert property ( // [RL21]
        s_frame_done ##0 (next_kind == KIND_NONE) |=> !busy && $stable(status_reg))
        else $error("invalid frame changed state");

endmodule

`default_nettype wire

// >>> bench/espc_host.sv
`default_nettype none

// behavioural spi host, mode 0; the link clock runs inside frames and, in stray, with select high
module espc_host (
    // core clock, used to pace select edges
    input wire logic clk,
    // serial link pins
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: deselected, link clock parked low
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // one bare select pulse after power-up, before any real frame
    task automatic arm();
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // link clock runs for another device on the shared bus; select stays high
    task automatic stray(input int n, input int half);
        @(posedge clk);
        #7;
        repeat (n) begin
            #(half) sck = 1'b1;
            #(half) sck = 1'b0;
        end
        @(posedge clk);
    endtask

    // n bits msb first; half is the link half period, so slow hosts are possible
    task automatic xfer(input logic [31:0] d, input int n, input int half,
                        output logic [7:0] rx);
        rx = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        si <= d[n-1];
        // select held 3 clk first so the core has armed before bit one
        repeat (3) @(posedge clk);
        #7;
        for (int i = n - 1; i >= 0; i--) begin
            #(half) sck = 1'b1;
            rx = {rx[6:0], so_oe ? so : 1'bz};
            #(half) sck = 1'b0;
            if (i > 0) begin
                si <= d[i-1];
            end
        end
        #(half);
        @(posedge clk);
        cs_n <= 1'b1;
        // a released data line must not keep showing the last bit
        si <= ~si;
    endtask
endmodule

`default_nettype wire

// >>> bench/tb.sv
`default_nettype none

module tb
    import espc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // shortened self-timed counts keep the run small
    localparam int WCNT = 50;
    localparam int ACNT = 100;
    localparam int SCNT = 80;

    logic clk;
    logic resetn;
    logic wp_n;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic busy;
    logic standby;
    logic deep_sleep;
    logic cycle_start;
    logic cycle_done;
    espc_kind_t cycle_kind;
    logic [7:0] status_reg;
    logic [7:0] exp_st;
    logic [7:0] rx;
    int n_mismatch;
    int checked;
    int cyc;

    // 10 MHz core clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    espc_ctrl #(
        .WRITE_CNT(WCNT),
        .ARRAY_ERASE_CNT(ACNT),
        .SECTOR_ERASE_CNT(SCNT)
    ) uut (
        .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .busy(busy), .standby(standby),
        .deep_sleep(deep_sleep), .cycle_start(cycle_start),
        .cycle_kind(cycle_kind), .cycle_done(cycle_done), .status_reg(status_reg)
    );

    espc_host host (
        .clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard, far above the thousand or so cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            summarize();
        end
    end

    // output may only move while the link clock is low
    always @(so) begin
        if (so_oe === 1'b1) begin
            check(sck, 1'b0);
        end
    end

    // a deselected device never drives the shared output
    always @(negedge clk) begin
        if (cs_n === 1'b1) begin
            check(so_oe, 1'b0);
        end
    end

    // one frame; cnt 0 means no cycle may start, else busy must stand cnt clk
    task automatic run(input logic [31:0] d, input int n, input espc_kind_t kind,
                       input int cnt);
        int k;
        k = 0;
        host.xfer(d, n, 15, rx);
        while (cycle_start !== 1'b1 && k < 12) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (cnt == 0) begin
            check(cycle_start, 1'b0);
            check(busy, 1'b0);
        end else begin
            check(cycle_kind, kind);
            check(standby, 1'b0);
            k = 0;
            while (busy === 1'b1 && k < cnt + 5) begin
                @(posedge clk);
                #1;
                k++;
            end
            check(k, cnt);
            check(cycle_done, 1'b1);
            check(standby, 1'b1);
        end
        check(status_reg, exp_st);
        repeat (4) @(posedge clk);
    endtask

    task automatic t_reset();
        check(standby, 1'b1);
        check(busy, 1'b0);
        check(cycle_kind, KIND_NONE);
        check(status_reg, 8'h00);
        check(so_oe, 1'b0);
    endtask

    // every cycle kind but array erase, protect pin low; the first status write turns protection on
    task automatic t_kinds();
        @(posedge clk);
        wp_n <= 1'b0;
        exp_st = 8'h8C;
        run(32'h0000_01FF, 16, KIND_STATUS, WCNT);
        run(32'h0200_10A5, 32, KIND_WRITE, WCNT);
        run(32'h0042_0100, 24, KIND_PAGE_ERASE, WCNT);
        run(32'h00D8_0100, 24, KIND_SECTOR_ERASE, SCNT);
    endtask

    // protection set: refusals, other work, pin high, short pin pulse
    task automatic t_protect();
        run(32'h0000_0100, 16, KIND_NONE, 0);
        run(32'h0000_00C7, 8, KIND_ARRAY_ERASE, ACNT);
        @(posedge clk);
        wp_n <= 1'b1;
        exp_st = 8'h84;
        run(32'h0000_0184, 16, KIND_STATUS, WCNT);
        fork
            run(32'h0000_0100, 16, KIND_NONE, 0);
            begin
                repeat (5) @(posedge clk);
                wp_n <= 1'b0;
                repeat (3) @(posedge clk);
                wp_n <= 1'b1;
            end
        join
    endtask

    // pin drop and a refused frame while a write runs must not cut it short
    task automatic t_disturb();
        fork
            run(32'h0200_10A5, 32, KIND_WRITE, WCNT);
            begin
                @(posedge cycle_start);
                @(posedge clk);
                wp_n <= 1'b0;
                host.xfer(32'h0000_0100, 16, 15, rx);
            end
        join
        wp_n <= 1'b1;
    endtask

    // host reads status, then partial frames are dropped
    task automatic t_read();
        host.xfer(32'h0000_0500, 16, 15, rx);
        repeat (12) @(posedge clk);
        #1;
        check(rx, exp_st);
        check(standby, 1'b1);
        run(32'h0000_001F, 12, KIND_NONE, 0);
        run(32'h0020_010A, 28, KIND_NONE, 0);
    endtask

    // deep sleep, ignored work while asleep, wake back to standby
    task automatic t_deep();
        run(32'h0000_00B9, 8, KIND_NONE, 0);
        check(deep_sleep, 1'b1);
        run(32'h0000_00C7, 8, KIND_NONE, 0);
        host.xfer(32'h0000_00AB, 8, 15, rx);
        repeat (12) @(posedge clk);
        #1;
        check(deep_sleep, 1'b0);
        check(standby, 1'b1);
        // odd count of stray clocks would hide the next frame if they were taken
        host.stray(3, 15);
        exp_st = 8'h00;
        run(32'h0000_0100, 16, KIND_STATUS, WCNT);
    endtask

    initial begin
        resetn = 1'b0;
        wp_n = 1'b1;
        n_mismatch = 0;
        checked = 0;
        cyc = 0;
        exp_st = 8'h00;
        rx = 8'h00;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        host.arm();
        t_kinds();
        t_protect();
        t_disturb();
        t_read();
        t_deep();
        summarize();
    end
endmodule

`default_nettype wire
